// File: logic/cpu_decode_pkg.sv
// Contract
// RQ1: the legacy sleep opcode is legal, four bytes, and changes no state.
// RQ2: signed and unsigned multiply take two registers, 16x16 product, two bytes.
// RQ3: short divide takes the low muldiv register over a register, 16/16, two bytes.
// RQ4: long divide takes the muldiv register pair over a register, 32/16, two bytes.
// RQ5: compare then decrement lowers the register by one or two per variant.
// RQ6: compare then increment raises the register by one or two per variant.
// RQ7: normalise counts shift steps of one register into a second register.
// RQ8: arithmetic right shift keeps the sign bit and is two bytes.
// RQ9: byte widen move fills the upper byte with sign copies or zeros.
// RQ10: branch on one jumps when the bit is one; variant clears it; four bytes.
// RQ11: branch on zero jumps when the bit is zero; variant sets it; four bytes.
// RQ12: push and call pushes a register then calls absolute address, four bytes.
// RQ13: context switch pushes a register then loads it with a word, four bytes.
// RQ14: trap enters a service routine by immediate number, two bytes.
// RQ15: bit copy moves one bit to another, optionally inverted, four bytes.
// RQ16: masked field changes only masked bits of high or low byte, four bytes.
// RQ17: extended page opens a paged sequence, register variant too, two or four bytes.
// RQ18: every multiply-accumulate coprocessor instruction is four bytes.
// RQ19: add with carry includes incoming carry, word or byte, two or four bytes.
// RQ20: instruction byte length is reported to fetch in the decode cycle.
package cpu_decode_pkg;

	// opcode byte: family in the upper nibble, variant in the lower
	localparam logic [3:0] FAM_ARITH = 4'h0;
	localparam logic [3:0] FAM_CARRY = 4'h1;
	localparam logic [3:0] FAM_MULDIV = 4'h2;
	localparam logic [3:0] FAM_CMPPTR = 4'h3;
	localparam logic [3:0] FAM_SHIFT = 4'h4;
	localparam logic [3:0] FAM_WIDEN = 4'h5;
	localparam logic [3:0] FAM_BITJMP = 4'h6;
	localparam logic [3:0] FAM_STACK = 4'h7;
	localparam logic [3:0] FAM_BITOP = 4'h8;
	localparam logic [3:0] FAM_EXT = 4'h9;
	localparam logic [3:0] FAM_MAC = 4'hA;
	localparam logic [7:0] LEGACY_SLEEP_OPCODE = 8'hB0;
	localparam logic [7:0] NOP_OPCODE = 8'hCC;

	// variant codes inside families
	localparam logic [3:0] VAR_NORMALISE = 4'h0;
	localparam logic [3:0] VAR_SIGN_SHIFT = 4'h2;
	localparam logic [3:0] VAR_PUSH_CALL = 4'h0;
	localparam logic [3:0] VAR_CONTEXT = 4'h2;
	localparam logic [3:0] VAR_TRAP = 4'h4;
	localparam logic [3:0] VAR_MAC_LOAD = 4'h8;
	localparam logic [3:0] VAR_MAC_STORE = 4'h9;
	localparam logic [3:0] VAR_MULDIV_LAST = 4'h5;

	localparam logic [2:0] LEN_SHORT = 3'h2;
	localparam logic [2:0] LEN_LONG = 3'h4;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ALU = 5'h01,
		OP_ADD_CARRY = 5'h02,
		OP_MULTIPLY = 5'h03,
		OP_DIVIDE = 5'h04,
		OP_LONG_DIVIDE = 5'h05,
		OP_CMP_DEC = 5'h06,
		OP_CMP_INC = 5'h07,
		OP_NORMALISE = 5'h08,
		OP_SIGN_SHIFT = 5'h09,
		OP_BYTE_WIDEN = 5'h0A,
		OP_BRANCH_ONE = 5'h0B,
		OP_BRANCH_ZERO = 5'h0C,
		OP_PUSH_CALL = 5'h0D,
		OP_CONTEXT = 5'h0E,
		OP_TRAP = 5'h0F,
		OP_BIT_COPY = 5'h10,
		OP_MASKED_FIELD = 5'h11,
		OP_EXT_PAGE = 5'h12,
		OP_MAC = 5'h13,
		OP_LEGACY_SLEEP = 5'h14,
		OP_ILLEGAL = 5'h1F
	} opClass_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] operand;
		logic [15:0] ext;
	} fetch_t;

	typedef struct packed {
		opClass_t op;
		logic [2:0] lenBytes;
		logic illegal;
		logic noAction;
		logic byteOp;
		logic useCarry;
		logic signedOp;
		logic divLong;
		logic stepTwo;
		logic stepUp;
		logic signExtend;
		logic modifyBit;
		logic invertBit;
		logic highByte;
		logic extReg;
		logic pushFirst;
		logic macLoad;
		logic macStore;
		logic [3:0] regA;
		logic [3:0] regB;
		logic [6:0] trapNum;
		logic [15:0] ext;
	} decoded_t;

	localparam decoded_t DECODED_RESET = '0;

endpackage

// File: logic/cpu_instruction_decoder.sv
`timescale 1ns/1ns
module cpu_instruction_decoder
	import cpu_decode_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic inValid,
	input wire fetch_t inFetch,
	output logic inReady,
	output logic [2:0] fetchLen,
	output logic outValid,
	input wire logic outReady,
	output decoded_t outInstr
);

	logic outValid_q;
	decoded_t outInstr_q;
	decoded_t decodedD;
	wire [3:0] fam;
	wire [3:0] vr;
	wire inFire;

	assign fam = inFetch.opcode[7:4];
	assign vr = inFetch.opcode[3:0];
	// one slot: accept whenever the slot is empty or being drained this cycle
	assign inReady = !outValid_q || outReady;
	assign inFire = inValid && inReady;

	wire famArith = fam == FAM_ARITH && vr[3:2] == 2'h0;
	wire famCarry = fam == FAM_CARRY && vr[3:2] == 2'h0;
	wire famMulDiv = fam == FAM_MULDIV && vr <= VAR_MULDIV_LAST;
	wire famCmpPtr = fam == FAM_CMPPTR && !vr[3];
	wire isNormalise = fam == FAM_SHIFT && vr == VAR_NORMALISE;
	wire isSignShift = fam == FAM_SHIFT && vr == VAR_SIGN_SHIFT;
	wire famWiden = fam == FAM_WIDEN && vr[3:2] == 2'h0;
	wire famBitJmp = fam == FAM_BITJMP && vr[3:2] == 2'h0;
	wire isPushCall = fam == FAM_STACK && vr == VAR_PUSH_CALL;
	wire isContext = fam == FAM_STACK && vr == VAR_CONTEXT;
	wire isTrap = fam == FAM_STACK && vr == VAR_TRAP;
	wire famBitOp = fam == FAM_BITOP && vr[3:2] == 2'h0;
	wire famExt = fam == FAM_EXT && vr[3:2] == 2'h0;
	wire famMac = fam == FAM_MAC;
	wire isSleep = inFetch.opcode == LEGACY_SLEEP_OPCODE;
	wire isNop = inFetch.opcode == NOP_OPCODE;

	wire isMultiply = famMulDiv && vr[3:1] == 3'h0;
	wire isDivide = famMulDiv && vr[2:1] == 2'h1;
	wire isLongDivide = famMulDiv && vr[2];

	// families with a short and a long form pick the long form by variant bit 0
	wire twoOrFour = famArith || famCarry || famCmpPtr || famWiden || famExt;
	wire fixedFour = famBitJmp || isPushCall || isContext || famBitOp || famMac || isSleep;
	wire legal = twoOrFour || fixedFour || famMulDiv || isNormalise || isSignShift
		|| isTrap || isNop;

	opClass_t opSel;
	assign opSel =
		isSleep ? OP_LEGACY_SLEEP : // RQ1
		isNop ? OP_NOP :
		famArith ? OP_ALU :
		famCarry ? OP_ADD_CARRY : // RQ19
		isMultiply ? OP_MULTIPLY : // RQ2
		isDivide ? OP_DIVIDE : // RQ3
		isLongDivide ? OP_LONG_DIVIDE : // RQ4
		(famCmpPtr && !vr[2]) ? OP_CMP_DEC : // RQ5
		(famCmpPtr && vr[2]) ? OP_CMP_INC : // RQ6
		isNormalise ? OP_NORMALISE : // RQ7
		isSignShift ? OP_SIGN_SHIFT : // RQ8
		famWiden ? OP_BYTE_WIDEN : // RQ9
		(famBitJmp && !vr[1]) ? OP_BRANCH_ONE : // RQ10
		(famBitJmp && vr[1]) ? OP_BRANCH_ZERO : // RQ11
		isPushCall ? OP_PUSH_CALL : // RQ12
		isContext ? OP_CONTEXT : // RQ13
		isTrap ? OP_TRAP : // RQ14
		(famBitOp && !vr[1]) ? OP_BIT_COPY : // RQ15
		(famBitOp && vr[1]) ? OP_MASKED_FIELD : // RQ16
		famExt ? OP_EXT_PAGE : // RQ17
		famMac ? OP_MAC : // RQ18
		OP_ILLEGAL;

	// length is combinational so fetch can step its counter in the same cycle
	assign fetchLen = (fixedFour || (twoOrFour && vr[0])) ? LEN_LONG : LEN_SHORT; // RQ20

	// the sleep opcode only flags noAction; no mode or clock output exists to touch
	assign decodedD = '{
		op: opSel,
		lenBytes: fetchLen,
		illegal: !legal,
		noAction: isSleep || isNop, // RQ1
		byteOp: (famArith || famCarry) && vr[1],
		useCarry: famCarry, // RQ19
		signedOp: famMulDiv && !vr[0],
		divLong: isLongDivide, // RQ4
		stepTwo: famCmpPtr && vr[1],
		stepUp: famCmpPtr && vr[2],
		signExtend: famWiden && !vr[1], // RQ9
		modifyBit: famBitJmp && vr[0],
		invertBit: famBitOp && !vr[1] && vr[0], // RQ15
		highByte: famBitOp && vr[1] && vr[0], // RQ16
		extReg: famExt && vr[1], // RQ17
		pushFirst: isPushCall || isContext, // RQ12 RQ13
		macLoad: famMac && vr == VAR_MAC_LOAD,
		macStore: famMac && vr == VAR_MAC_STORE,
		regA: inFetch.operand[7:4],
		regB: inFetch.operand[3:0],
		trapNum: inFetch.operand[6:0], // RQ14
		ext: inFetch.ext
	};

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			outValid_q <= 1'b0;
		end else if (inReady) begin
			outValid_q <= inValid;
		end
	end

	// the payload only loads on an accepted fetch, so it holds steady under stall
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			outInstr_q <= DECODED_RESET;
		end else if (inFire) begin
			outInstr_q <= decodedD;
		end
	end

	assign outValid = outValid_q;
	assign outInstr = outInstr_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_sleep_quiet: assert property ( // RQ1
		inFire && inFetch.opcode == LEGACY_SLEEP_OPCODE |=> outValid && outInstr.op == OP_LEGACY_SLEEP
			&& !outInstr.illegal && outInstr.noAction && outInstr.lenBytes == 3'h4)
		else $error("legacy sleep opcode not decoded as quiet four-byte op");

	chk_multiply_form: assert property ( // RQ2
		inFire && fam == FAM_MULDIV && vr[3:1] == 3'h0 |=> outInstr.op == OP_MULTIPLY
			&& outInstr.lenBytes == 3'h2 && outInstr.signedOp == !$past(inFetch.opcode[0])
			&& outInstr.regA == $past(inFetch.operand[7:4]) && outInstr.regB == $past(inFetch.operand[3:0]))
		else $error("multiply decode wrong");

	chk_short_divide: assert property ( // RQ3
		inFire && fam == FAM_MULDIV && vr[3:1] == 3'h1 |=> outInstr.op == OP_DIVIDE
			&& !outInstr.divLong && outInstr.lenBytes == 3'h2)
		else $error("short divide decode wrong");

	chk_long_divide: assert property ( // RQ4
		inFire && fam == FAM_MULDIV && vr[3:1] == 3'h2 |=> outInstr.op == OP_LONG_DIVIDE
			&& outInstr.divLong && outInstr.lenBytes == 3'h2)
		else $error("long divide decode wrong");

	chk_cmp_decrement: assert property ( // RQ5
		inFire && fam == FAM_CMPPTR && vr[3:2] == 2'h0 |=> outInstr.op == OP_CMP_DEC
			&& !outInstr.stepUp && outInstr.stepTwo == $past(inFetch.opcode[1])
			&& outInstr.lenBytes == ($past(inFetch.opcode[0]) ? 3'h4 : 3'h2))
		else $error("compare-decrement decode wrong");

	chk_cmp_increment: assert property ( // RQ6
		inFire && fam == FAM_CMPPTR && vr[3:2] == 2'h1 |=> outInstr.op == OP_CMP_INC
			&& outInstr.stepUp && outInstr.stepTwo == $past(inFetch.opcode[1]))
		else $error("compare-increment decode wrong");

	chk_normalise_regs: assert property ( // RQ7
		inFire && inFetch.opcode == {FAM_SHIFT, VAR_NORMALISE} |=> outInstr.op == OP_NORMALISE
			&& outInstr.regA == $past(inFetch.operand[7:4]) && outInstr.regB == $past(inFetch.operand[3:0]))
		else $error("normalise decode wrong");

	chk_sign_shift: assert property ( // RQ8
		inFire && inFetch.opcode == {FAM_SHIFT, VAR_SIGN_SHIFT} |=> outInstr.op == OP_SIGN_SHIFT
			&& outInstr.lenBytes == 3'h2)
		else $error("sign shift decode wrong");

	chk_byte_widen: assert property ( // RQ9
		inFire && fam == FAM_WIDEN && vr[3:2] == 2'h0 |=> outInstr.op == OP_BYTE_WIDEN
			&& outInstr.signExtend == !$past(inFetch.opcode[1]))
		else $error("byte widen decode wrong");

	chk_branch_one: assert property ( // RQ10
		inFire && fam == FAM_BITJMP && vr[3:1] == 3'h0 |=> outInstr.op == OP_BRANCH_ONE
			&& outInstr.modifyBit == $past(inFetch.opcode[0]) && outInstr.lenBytes == 3'h4)
		else $error("branch on one decode wrong");

	chk_branch_zero: assert property ( // RQ11
		inFire && fam == FAM_BITJMP && vr[3:1] == 3'h1 |=> outInstr.op == OP_BRANCH_ZERO
			&& outInstr.modifyBit == $past(inFetch.opcode[0]) && outInstr.lenBytes == 3'h4)
		else $error("branch on zero decode wrong");

	chk_push_call: assert property ( // RQ12
		inFire && inFetch.opcode == {FAM_STACK, VAR_PUSH_CALL} |=> outInstr.op == OP_PUSH_CALL
			&& outInstr.pushFirst && outInstr.ext == $past(inFetch.ext) && outInstr.lenBytes == 3'h4)
		else $error("push and call decode wrong");

	chk_context_switch: assert property ( // RQ13
		inFire && inFetch.opcode == {FAM_STACK, VAR_CONTEXT} |=> outInstr.op == OP_CONTEXT
			&& outInstr.pushFirst && outInstr.lenBytes == 3'h4)
		else $error("context switch decode wrong");

	chk_trap_number: assert property ( // RQ14
		inFire && inFetch.opcode == {FAM_STACK, VAR_TRAP} |=> outInstr.op == OP_TRAP
			&& outInstr.trapNum == $past(inFetch.operand[6:0]) && outInstr.lenBytes == 3'h2)
		else $error("trap decode wrong");

	chk_bit_copy: assert property ( // RQ15
		inFire && fam == FAM_BITOP && vr[3:1] == 3'h0 |=> outInstr.op == OP_BIT_COPY
			&& outInstr.invertBit == $past(inFetch.opcode[0]) && outInstr.lenBytes == 3'h4)
		else $error("bit copy decode wrong");

	chk_masked_field: assert property ( // RQ16
		inFire && fam == FAM_BITOP && vr[3:1] == 3'h1 |=> outInstr.op == OP_MASKED_FIELD
			&& outInstr.highByte == $past(inFetch.opcode[0]) && outInstr.lenBytes == 3'h4)
		else $error("masked field decode wrong");

	chk_ext_page: assert property ( // RQ17
		inFire && fam == FAM_EXT && vr[3:2] == 2'h0 |=> outInstr.op == OP_EXT_PAGE
			&& outInstr.extReg == $past(inFetch.opcode[1])
			&& outInstr.lenBytes == ($past(inFetch.opcode[0]) ? 3'h4 : 3'h2))
		else $error("extended page decode wrong");

	chk_mac_length: assert property ( // RQ18
		inValid && fam == FAM_MAC |-> fetchLen == 3'h4)
		else $error("coprocessor op not four bytes");

	chk_add_carry: assert property ( // RQ19
		inFire && fam == FAM_CARRY && vr[3:2] == 2'h0 |=> outInstr.op == OP_ADD_CARRY
			&& outInstr.useCarry && outInstr.byteOp == $past(inFetch.opcode[1]))
		else $error("add with carry decode wrong");

	chk_length_follows: assert property ( // RQ20
		inFire |=> outInstr.lenBytes == $past(fetchLen))
		else $error("reported length differs from decoded length");

	chk_stall_hold: assert property (
		outValid && !outReady |=> outValid && $stable(outInstr))
		else $error("decoded instruction changed while stalled");

	// reset is checked with the disable lifted, since every other check is muted while it is low
	chk_reset_clears: assert property (disable iff (1'b0)
		!rst_n |=> !outValid && outInstr == DECODED_RESET)
		else $error("slot not cleared by reset");

	chk_refuse_full: assert property ( // RQ20
		outValid && !outReady |-> !inReady)
		else $error("fetch accepted while slot full");

	chk_accept_free: assert property ( // RQ20
		!outValid || outReady |-> inReady)
		else $error("fetch refused while slot free");

	chk_take_shows: assert property ( // RQ20
		inFire |=> outValid)
		else $error("accepted fetch did not reach the slot");

	chk_drain_empty: assert property (
		outValid && outReady && !inValid |=> !outValid)
		else $error("slot still full after drain");

	chk_ext_carried: assert property ( // RQ12 RQ13 RQ16
		inFire |=> outInstr.ext == $past(inFetch.ext))
		else $error("extension word not carried");

	chk_sleep_no_effect: assert property ( // RQ1
		inFire && inFetch.opcode == LEGACY_SLEEP_OPCODE |=> !outInstr.pushFirst && !outInstr.modifyBit
			&& !outInstr.useCarry && !outInstr.macLoad && !outInstr.macStore && !outInstr.extReg)
		else $error("legacy sleep opcode carries an action flag");

	chk_sleep_length_now: assert property ( // RQ1
		inValid && inFetch.opcode == LEGACY_SLEEP_OPCODE |-> fetchLen == 3'h4)
		else $error("legacy sleep opcode length not four");

	chk_divide_sign: assert property ( // RQ3 RQ4
		inFire && fam == FAM_MULDIV && (vr[3:1] == 3'h1 || vr[3:1] == 3'h2)
			|=> outInstr.signedOp == !$past(inFetch.opcode[0]) && !outInstr.illegal)
		else $error("divide signedness wrong");

	chk_cmp_inc_length: assert property ( // RQ6
		inFire && fam == FAM_CMPPTR && vr[3:2] == 2'h1
			|=> outInstr.lenBytes == ($past(inFetch.opcode[0]) ? 3'h4 : 3'h2))
		else $error("compare-increment length wrong");

	chk_normalise_length: assert property ( // RQ7
		inFire && inFetch.opcode == {FAM_SHIFT, VAR_NORMALISE}
			|=> outInstr.lenBytes == 3'h2 && !outInstr.illegal)
		else $error("normalise length wrong");

	chk_widen_length: assert property ( // RQ9
		inFire && fam == FAM_WIDEN && vr[3:2] == 2'h0
			|=> outInstr.lenBytes == ($past(inFetch.opcode[0]) ? 3'h4 : 3'h2))
		else $error("byte widen length wrong");

	chk_mac_flags: assert property ( // RQ18
		inFire && fam == FAM_MAC
			|=> outInstr.op == OP_MAC && !outInstr.illegal && outInstr.lenBytes == 3'h4
			&& outInstr.macLoad == ($past(inFetch.opcode[3:0]) == VAR_MAC_LOAD)
			&& outInstr.macStore == ($past(inFetch.opcode[3:0]) == VAR_MAC_STORE))
		else $error("coprocessor op decode wrong");

	chk_carry_length: assert property ( // RQ19
		inFire && fam == FAM_CARRY && vr[3:2] == 2'h0
			|=> outInstr.lenBytes == ($past(inFetch.opcode[0]) ? 3'h4 : 3'h2))
		else $error("add with carry length wrong");

	chk_len_two_four: assert property ( // RQ20
		inValid |-> fetchLen == 3'h2 || fetchLen == 3'h4)
		else $error("reported length neither two nor four");

	chk_illegal_muldiv: assert property ( // RQ20
		inFire && fam == FAM_MULDIV && vr > VAR_MULDIV_LAST
			|=> outInstr.op == OP_ILLEGAL && outInstr.illegal && outInstr.lenBytes == 3'h2)
		else $error("unused muldiv code not flagged illegal");

	chk_shift_illegal: assert property ( // RQ8
		inFire && fam == FAM_SHIFT && vr != VAR_NORMALISE && vr != VAR_SIGN_SHIFT
			|=> outInstr.illegal && !outInstr.noAction)
		else $error("unused shift code not flagged illegal");

	chk_nop_quiet: assert property (
		inFire && inFetch.opcode == NOP_OPCODE |=> outInstr.op == OP_NOP && outInstr.noAction
			&& !outInstr.illegal && outInstr.lenBytes == 3'h2)
		else $error("null operation decode wrong");

	chk_trap_no_push: assert property ( // RQ14
		inFire && inFetch.opcode == {FAM_STACK, VAR_TRAP} |=> !outInstr.pushFirst && !outInstr.illegal)
		else $error("trap decoded with a push");

	chk_context_regs: assert property ( // RQ13
		inFire && inFetch.opcode == {FAM_STACK, VAR_CONTEXT}
			|=> outInstr.regA == $past(inFetch.operand[7:4])
			&& outInstr.ext == $past(inFetch.ext))
		else $error("context switch operands not carried");

	chk_branch_target: assert property ( // RQ10 RQ11
		inFire && fam == FAM_BITJMP && vr[3:2] == 2'h0 |=> outInstr.ext == $past(inFetch.ext)
			&& !outInstr.pushFirst && !outInstr.illegal)
		else $error("bit jump operands not carried");

	chk_arith_form: assert property (
		inFire && fam == FAM_ARITH && vr[3:2] == 2'h0 |=> outInstr.op == OP_ALU && !outInstr.useCarry
			&& outInstr.byteOp == $past(inFetch.opcode[1])
			&& outInstr.lenBytes == ($past(inFetch.opcode[0]) ? 3'h4 : 3'h2))
		else $error("plain arithmetic decode wrong");

	cov_sleep: cover property (inFire && inFetch.opcode == LEGACY_SLEEP_OPCODE);
	cov_mac_store: cover property (inFire && inFetch.opcode == {FAM_MAC, VAR_MAC_STORE});
	cov_stall: cover property (outValid && !outReady ##1 outValid && outReady);
	cov_back_to_back: cover property (inFire ##1 inFire);
	cov_illegal: cover property (inFire && fam == FAM_MULDIV && vr > VAR_MULDIV_LAST);

endmodule

// File: tb/pipeline_sink_model.sv
`timescale 1ns/1ns
module pipeline_sink_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic slow,
	output logic outReady
);
	integer seed;
	initial begin
		seed = 32'hB51E;
	end
	// a slow pipeline refuses at random, so stalls land mid-burst and back to back
	always @(posedge clk_sys) begin
		if (!rst_n || !slow) begin
			outReady <= 1'b1;
		end else begin
			outReady <= 1'($random(seed));
		end
	end
endmodule

// File: tb/cpu_instruction_decoder_tb_top.sv
`timescale 1ns/1ns
module cpu_instruction_decoder_tb_top import cpu_decode_pkg::*;;
	logic clk_sys, rst_n, inValid, outReady, inReady, outValid, slow;
	logic [2:0] fetchLen;
	fetch_t inFetch, seenF;
	decoded_t outInstr;
	logic [9:0] e;
	logic [3:0] fl;
	integer num_errors, num_checks, seed;
	integer cycles = 0;
	fetch_t pending[$];
	logic [7:0] corners[6] = '{8'hB0, 8'hB0, 8'h25, 8'h26, 8'hA8, 8'hA9};

	cpu_instruction_decoder uut (.clk_sys(clk_sys), .rst_n(rst_n), .inValid(inValid), .inFetch(inFetch),
		.inReady(inReady), .fetchLen(fetchLen), .outValid(outValid), .outReady(outReady), .outInstr(outInstr));
	pipeline_sink_model sink (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .outReady(outReady));

	function automatic logic [9:0] expVec(logic [7:0] oc);
		logic [3:0] v;
		logic lo;
		opClass_t op;
		logic [2:0] len;
		v = oc[3:0];
		lo = v[3:2] == 2'h0;
		case (oc[7:4])
			FAM_ARITH: op = lo ? OP_ALU : OP_ILLEGAL;
			FAM_CARRY: op = lo ? OP_ADD_CARRY : OP_ILLEGAL;
			FAM_MULDIV: op = v > VAR_MULDIV_LAST ? OP_ILLEGAL : v[2] ? OP_LONG_DIVIDE : v[1] ? OP_DIVIDE : OP_MULTIPLY;
			FAM_CMPPTR: op = v[3] ? OP_ILLEGAL : v[2] ? OP_CMP_INC : OP_CMP_DEC;
			FAM_SHIFT: op = v == VAR_NORMALISE ? OP_NORMALISE : v == VAR_SIGN_SHIFT ? OP_SIGN_SHIFT : OP_ILLEGAL;
			FAM_WIDEN: op = lo ? OP_BYTE_WIDEN : OP_ILLEGAL;
			FAM_BITJMP: op = !lo ? OP_ILLEGAL : v[1] ? OP_BRANCH_ZERO : OP_BRANCH_ONE;
			FAM_STACK: op = v == VAR_PUSH_CALL ? OP_PUSH_CALL : v == VAR_CONTEXT ? OP_CONTEXT
				: v == VAR_TRAP ? OP_TRAP : OP_ILLEGAL;
			FAM_BITOP: op = !lo ? OP_ILLEGAL : v[1] ? OP_MASKED_FIELD : OP_BIT_COPY;
			FAM_EXT: op = lo ? OP_EXT_PAGE : OP_ILLEGAL;
			FAM_MAC: op = OP_MAC;
			default: op = oc == LEGACY_SLEEP_OPCODE ? OP_LEGACY_SLEEP : oc == NOP_OPCODE ? OP_NOP : OP_ILLEGAL;
		endcase
		len = (op inside {OP_ALU, OP_ADD_CARRY, OP_CMP_DEC, OP_CMP_INC, OP_BYTE_WIDEN, OP_EXT_PAGE})
			? (v[0] ? LEN_LONG : LEN_SHORT)
			: (op inside {OP_BRANCH_ONE, OP_BRANCH_ZERO, OP_PUSH_CALL, OP_CONTEXT, OP_BIT_COPY,
				OP_MASKED_FIELD, OP_MAC, OP_LEGACY_SLEEP}) ? LEN_LONG : LEN_SHORT;
		return {op, len, op == OP_ILLEGAL, op inside {OP_LEGACY_SLEEP, OP_NOP}};
	endfunction

	// upper pair is what the decoder reported, lower pair what the opcode calls for
	function automatic logic [3:0] flags(decoded_t d, logic [7:0] oc);
		case (oc[7:4])
			FAM_ARITH: return {1'b0, d.byteOp, 1'b0, oc[1]};
			FAM_CARRY: return {d.useCarry, d.byteOp, 1'b1, oc[1]};
			FAM_MULDIV: return {d.divLong, d.signedOp, oc[2], !oc[0]};
			FAM_CMPPTR: return {d.stepUp, d.stepTwo, oc[2], oc[1]};
			FAM_WIDEN: return {1'b0, d.signExtend, 1'b0, !oc[1]};
			FAM_BITJMP: return {1'b0, d.modifyBit, 1'b0, oc[0]};
			FAM_BITOP: return {1'b0, oc[1] ? d.highByte : d.invertBit, 1'b0, oc[0]};
			FAM_EXT: return {d.extReg, 1'b0, oc[1], 1'b0};
			FAM_MAC: return {d.macStore, d.macLoad, oc[3:0] == VAR_MAC_STORE, oc[3:0] == VAR_MAC_LOAD};
			default: return 4'h0;
		endcase
	endfunction

	function automatic fetch_t randFetch(logic [7:0] oc);
		return {oc, 8'($random(seed)), 16'($random(seed))};
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// the offer stands unchanged until an edge that finds inReady high
	task automatic offer(input fetch_t f);
		logic [9:0] le;
		logic r;
		inValid <= 1'b1;
		inFetch <= f;
		le = expVec(f.opcode);
		@(negedge clk_sys);
		check(fetchLen, le[4:2]);
		r = inReady;
		while (!r) begin
			@(posedge clk_sys);
			@(negedge clk_sys);
			r = inReady;
		end
		@(posedge clk_sys);
		pending.push_back(f);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			test_done();
		end
	end

	// takes are judged half a cycle early, where outputs have settled
	always @(negedge clk_sys) begin
		if (rst_n && outValid && !outReady) check(inReady, 1'b0);
		if (rst_n && !outValid) check(inReady, 1'b1);
		if (rst_n && outValid && outReady) begin
			if (pending.size() == 0) begin
				check(outValid, 1'b0);
			end else begin
				seenF = pending.pop_front();
				e = expVec(seenF.opcode);
				fl = flags(outInstr, seenF.opcode);
				check({outInstr.op, outInstr.lenBytes, outInstr.illegal, outInstr.noAction}, e);
				if (!e[1]) check(fl[3:2], fl[1:0]);
				if (e[9:5] == OP_TRAP) check(outInstr.trapNum, seenF.operand[6:0]);
				if (e[9:5] inside {OP_MULTIPLY, OP_NORMALISE}) check({outInstr.regA, outInstr.regB}, seenF.operand);
				check(outInstr.ext, seenF.ext);
			end
		end
	end

	initial begin
		seed = 32'hB51E;
		num_errors = 0;
		num_checks = 0;
		rst_n = 1'b0;
		inValid = 1'b0;
		inFetch = '0;
		slow = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 256; i++) offer(randFetch(8'(i)));
		inValid <= 1'b0;
		$display("opcode sweep test done");
		@(posedge clk_sys);
		slow <= 1'b1;
		foreach (corners[k]) offer(randFetch(corners[k]));
		repeat (300) offer(randFetch(8'($random(seed))));
		inValid <= 1'b0;
		repeat (60) @(posedge clk_sys);
		check(pending.size(), 0);
		$display("stalled random test done");
		test_done();
	end
endmodule
